// ---- design/rtc_ctrl_pkg.sv ----
// package: register offsets, field positions, reset values and timing counts
// assumes: byte-wide register access decoded by the serial bus front end
package rtc_ctrl_pkg;
  // register offsets
  localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_TWO_OFFSET = 8'h01;
  // control_status_one field positions
  localparam int STOP_BIT     = 5;
  localparam int SOFTRST_LSB  = 3;
  localparam int COMP_IE_BIT  = 2;
  localparam int HOUR_12_BIT  = 1;
  localparam int RSVD0_BIT    = 0;
  // control_status_two field positions
  localparam int ALARM_IE_BIT = 7;
  localparam int ALARM_FL_BIT = 6;
  localparam int MIN_IE_BIT   = 5;
  localparam int HALF_IE_BIT  = 4;
  localparam int CNTDN_FL_BIT = 3;
  localparam int CLKSEL_LSB   = 0;
  // reset values
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  // clock-output select codes
  localparam logic [2:0] CLKSEL_FAST   = 3'h0;
  localparam logic [2:0] CLKSEL_SLOWHZ = 3'h5;
  localparam logic [2:0] CLKSEL_ONEHZ  = 3'h6;
  localparam logic [2:0] CLKSEL_LOW    = 3'h7;
  // prescaler: stage index of F2 (bit 0 is F1), and the 1 Hz tap
  localparam int PRESC_BITS   = 15;
  localparam int PRESC_STOP_LO = 1;
  localparam int ONEHZ_TAP    = 14;
endpackage : rtc_ctrl_pkg

// ---- design/rtc_control_status_regs.sv ----
// control and status registers one and two with stop, clock-output and irq gating
// assumes: osc_tick is a one-cycle pulse at 32.768 kHz; bus writes/reads are single-cycle strobes

module rtc_control_status_regs
  import rtc_ctrl_pkg::*;
#(
  parameter int PRESC_W = PRESC_BITS
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // register access
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // timing and events
  input  wire logic       oscTick,
  input  wire logic       compCycle,
  input  wire logic       alarmEvent,
  // outputs
  output logic            timeTick,
  output logic            clkOut,
  output logic            irqOut
);

  logic [7:0]         ctrlOne_q;
  logic [7:0]         ctrlTwo_q;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic               stopped;
  logic               wrOne;
  logic               wrTwo;
  logic               clkSel;
  logic [2:0]         sel;

  assign wrOne   = regWrite && (regAddr == CTRL_ONE_OFFSET);
  assign wrTwo   = regWrite && (regAddr == CTRL_TWO_OFFSET);
  assign stopped = ctrlOne_q[STOP_BIT];
  assign sel     = ctrlTwo_q[CLKSEL_LSB +: 3];

  // reserved bit always held at zero so software writes cannot set it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrlOne_q <= CTRL_ONE_RESET;
    end else if (wrOne) begin
      ctrlOne_q <= regWdata & 8'hFE;
    end
  end

  // alarm flag clear
  // set wins over a simultaneous write-zero clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrlTwo_q <= CTRL_TWO_RESET;
    end else begin
      if (wrTwo) begin
        ctrlTwo_q[7]   <= regWdata[ALARM_IE_BIT];
        ctrlTwo_q[5:0] <= regWdata[5:0];
      end
      if (alarmEvent) begin
        ctrlTwo_q[ALARM_FL_BIT] <= 1'b1;
      end else if (wrTwo && !regWdata[ALARM_FL_BIT]) begin
        ctrlTwo_q[ALARM_FL_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        CTRL_ONE_OFFSET: regRdata <= ctrlOne_q;
        CTRL_TWO_OFFSET: regRdata <= ctrlTwo_q;
        default:         regRdata <= 8'h00;
      endcase
    end
  end

  always_comb begin
    presc_d = presc_q;
    if (oscTick) begin
      presc_d = presc_q + 1'b1;
    end
    if (stopped) begin
      presc_d[PRESC_W-1:PRESC_STOP_LO] = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      timeTick <= 1'b0;
    end else begin
      timeTick <= !stopped && oscTick && (&presc_q);
    end
  end

  // top two taps
  // 32.768 kHz is the tick itself, so its duty is one sys_clk cycle
  always_comb begin
    case (sel)
      CLKSEL_FAST:  clkSel = oscTick;
      CLKSEL_LOW:   clkSel = 1'b0;
      CLKSEL_ONEHZ: clkSel = presc_d[ONEHZ_TAP];
      default:      clkSel = presc_d[sel - 3'h1];
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clkOut <= 1'b0;
    end else begin
      clkOut <= clkSel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= (ctrlOne_q[COMP_IE_BIT] && compCycle) ||
                (ctrlTwo_q[ALARM_IE_BIT] && ctrlTwo_q[ALARM_FL_BIT]);
    end
  end

  property p_stop_holds;
    @(posedge sys_clk) disable iff (!rst_b)
      stopped |=> (presc_q[PRESC_W-1:PRESC_STOP_LO] == '0);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("prescaler upper stages run while stopped");

  property p_no_tick_stopped;
    @(posedge sys_clk) disable iff (!rst_b)
      $past(stopped) |-> !timeTick;
  endproperty
  a_no_tick_stopped: assert property (p_no_tick_stopped) else $error("seconds tick while stopped");

  property p_fast_runs;
    @(posedge sys_clk) disable iff (!rst_b)
      (stopped && oscTick) |=> (presc_q[0] != $past(presc_q[0]));
  endproperty
  a_fast_runs: assert property (p_fast_runs) else $error("fast stage frozen while stopped");

  property p_comp_pulse;
    @(posedge sys_clk) disable iff (!rst_b)
      (ctrlOne_q[COMP_IE_BIT] && compCycle) |=> irqOut;
  endproperty
  a_comp_pulse: assert property (p_comp_pulse) else $error("missing compensation pulse");

  property p_no_irq_disabled;
    @(posedge sys_clk) disable iff (!rst_b)
      (!ctrlOne_q[COMP_IE_BIT] && !ctrlTwo_q[ALARM_IE_BIT]) |=> !irqOut;
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("interrupt while all enables off");

  property p_alarm_irq;
    @(posedge sys_clk) disable iff (!rst_b)
      (ctrlTwo_q[ALARM_IE_BIT] && ctrlTwo_q[ALARM_FL_BIT]) |=> irqOut;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm interrupt not raised");

  property p_flag_set;
    @(posedge sys_clk) disable iff (!rst_b)
      alarmEvent |=> ctrlTwo_q[ALARM_FL_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm flag not set by event");

  property p_flag_keep;
    @(posedge sys_clk) disable iff (!rst_b)
      (wrTwo && regWdata[ALARM_FL_BIT] && ctrlTwo_q[ALARM_FL_BIT]) |=> ctrlTwo_q[ALARM_FL_BIT];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("writing one changed alarm flag");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (wrTwo && !regWdata[ALARM_FL_BIT] && !alarmEvent) |=> !ctrlTwo_q[ALARM_FL_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write zero did not clear flag");

  property p_clk_low;
    @(posedge sys_clk) disable iff (!rst_b)
      (sel == CLKSEL_LOW) [*2] |=> !clkOut;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock output not held low");

  property p_clk_fast;
    @(posedge sys_clk) disable iff (!rst_b)
      (sel == CLKSEL_FAST) |=> (clkOut == $past(oscTick));
  endproperty
  a_clk_fast: assert property (p_clk_fast) else $error("fast clock output not following the tick");

  property p_read_two;
    @(posedge sys_clk) disable iff (!rst_b)
      (regRead && (regAddr == CTRL_TWO_OFFSET)) |=> (regRdata == $past(ctrlTwo_q));
  endproperty
  a_read_two: assert property (p_read_two) else $error("status two read data wrong");

  c_stop: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(stopped));
  c_alarm: cover property (@(posedge sys_clk) disable iff (!rst_b) alarmEvent ##1 irqOut);
  c_comp: cover property (@(posedge sys_clk) disable iff (!rst_b) compCycle && ctrlOne_q[COMP_IE_BIT]);
  c_clear: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(ctrlTwo_q[ALARM_FL_BIT]));

endmodule // rtc_control_status_regs

// ---- sim/rtc_control_status_regs_tb.sv ----
// testbench for the control and status register block
// assumes: inputs driven at the falling edge, outputs sampled there
module rtc_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_ctrl_pkg::*;
  logic       sys_clk    = 1'b0;
  logic       rst_b      = 1'b0;
  logic       regWrite   = 1'b0;
  logic       regRead    = 1'b0;
  logic [7:0] regAddr    = 8'h00;
  logic [7:0] regWdata   = 8'h00;
  logic       oscTick    = 1'b0;
  logic       compCycle  = 1'b0;
  logic       alarmEvent = 1'b0;
  logic [7:0] regRdata;
  logic       timeTick;
  logic       clkOut;
  logic       irqOut;
  logic [7:0] d;
  logic [7:0] w;
  logic [7:0] acc;
  logic       prevClk;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc        = 0;
  int         ticks;
  int         rises;
  always #4 sys_clk = ~sys_clk;
  rtc_control_status_regs dut_u (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .regWrite   (regWrite),
    .regRead    (regRead),
    .regAddr    (regAddr),
    .regWdata   (regWdata),
    .regRdata   (regRdata),
    .oscTick    (oscTick),
    .compCycle  (compCycle),
    .alarmEvent (alarmEvent),
    .timeTick   (timeTick),
    .clkOut     (clkOut),
    .irqOut     (irqOut)
  );
  // register images expected after a write
  function automatic logic [7:0] expOne(input logic [7:0] v);
    return {v[7:1], 1'b0};
  endfunction
  function automatic logic [7:0] expTwo(input logic [7:0] v, input logic flag);
    return {v[7], flag, v[5:0]};
  endfunction
  // select s halves from 32.768 kHz, so 128 ticks hold 128 >> s periods
  function automatic logic [7:0] expRises(input int s);
    return 8'(128 >> s);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // an idle cycle after the strobe lets back-to-back calls keep one assignment per step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = v;
    @(negedge sys_clk);
    regWrite = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    regRead = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRead = 1'b0;
    @(negedge sys_clk);
    v = regRdata;
  endtask
  // or of irqOut, clkOut or timeTick over n cycles, oscillator ticking; clkOut rises counted
  task automatic watch(input int n, input int sel);
    acc = 8'h00;
    rises = 0;
    prevClk = clkOut;
    repeat (n) begin
      oscTick = ~oscTick;
      @(negedge sys_clk);
      if (clkOut && !prevClk) rises++;
      prevClk = clkOut;
      acc = acc | {7'h00, (sel == 0) ? irqOut : (sel == 1) ? clkOut : timeTick};
    end
  endtask
  // raise one event input for a cycle, then count irqOut high samples
  task automatic pulse(input bit comp);
    acc = 8'h00;
    if (comp) compCycle = 1'b1;
    else alarmEvent = 1'b1;
    repeat (4) begin
      @(negedge sys_clk);
      compCycle  = 1'b0;
      alarmEvent = 1'b0;
      acc = acc + {7'h00, irqOut};
    end
  endtask
  // ceiling: one full second of ticks plus a few thousand cycles of other tests
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 40000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(79));
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    rd(CTRL_ONE_OFFSET, d);
    check(d, CTRL_ONE_RESET);
    rd(CTRL_TWO_OFFSET, d);
    check(d, CTRL_TWO_RESET);
    rd(8'h02, d);
    check(d, 8'h00);
    // random images; a written one on the alarm flag must not set it
    for (int i = 0; i < 24; i++) begin
      w = 8'($urandom);
      wr(CTRL_TWO_OFFSET, w);
      rd(CTRL_TWO_OFFSET, d);
      check(d, expTwo(w, 1'b0));
      w = 8'($urandom);
      wr(CTRL_ONE_OFFSET, w);
      rd(CTRL_ONE_OFFSET, d);
      check(d, expOne(w));
    end
    // mid-run reset brings both registers back
    rst_b = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    rd(CTRL_ONE_OFFSET, d);
    check(d, CTRL_ONE_RESET);
    rd(CTRL_TWO_OFFSET, d);
    check(d, CTRL_TWO_RESET);
    // stopped: slow taps and seconds tick frozen, top two taps still run
    wr(CTRL_ONE_OFFSET, 8'h20);
    for (int s = 2; s < 8; s++) begin
      wr(CTRL_TWO_OFFSET, 8'(s));
      watch(40, 1);
      check(acc, 8'h00);
    end
    for (int s = 0; s < 2; s++) begin
      wr(CTRL_TWO_OFFSET, 8'(s));
      watch(12, 1);
      check(acc, 8'h01);
    end
    watch(60, 2);
    check(acc, 8'h00);
    wr(CTRL_ONE_OFFSET, 8'h00);
    wr(CTRL_TWO_OFFSET, {5'h00, CLKSEL_LOW});
    watch(600, 1);
    check(acc, 8'h00);
    wr(CTRL_TWO_OFFSET, {5'h00, CLKSEL_FAST});
    watch(12, 1);
    check(acc, 8'h01);
    // halving taps: rises over 128 ticks after a short settle
    for (int s = 1; s < 6; s++) begin
      wr(CTRL_TWO_OFFSET, 8'(s));
      watch(2, 1);
      watch(256, 1);
      check(8'(rises), expRises(s));
    end
    // one second of ticks: one seconds tick and one 1 Hz rise
    wr(CTRL_TWO_OFFSET, {5'h00, CLKSEL_ONEHZ});
    ticks = 0;
    rises = 0;
    prevClk = clkOut;
    oscTick = 1'b1;
    repeat (32768) begin
      @(negedge sys_clk);
      if (timeTick) ticks++;
      if (clkOut && !prevClk) rises++;
      prevClk = clkOut;
    end
    oscTick = 1'b0;
    check(8'(ticks), 8'h01);
    check(8'(rises), 8'h01);
    pulse(1'b1);
    check(acc, 8'h00);
    wr(CTRL_ONE_OFFSET, 8'h04);
    pulse(1'b1);
    check(acc, 8'h01);
    wr(CTRL_ONE_OFFSET, 8'h00);
    wr(CTRL_TWO_OFFSET, 8'h00);
    pulse(1'b0);
    check(acc, 8'h00);
    rd(CTRL_TWO_OFFSET, d);
    check(d, expTwo(8'h00, 1'b1));
    // writing one keeps the flag
    wr(CTRL_TWO_OFFSET, 8'hC0);
    watch(3, 0);
    check(acc, 8'h01);
    rd(CTRL_TWO_OFFSET, d);
    check(d, expTwo(8'hC0, 1'b1));
    // a clear racing a new event leaves the flag set
    regWrite   = 1'b1;
    regAddr    = CTRL_TWO_OFFSET;
    regWdata   = 8'h80;
    alarmEvent = 1'b1;
    @(negedge sys_clk);
    regWrite   = 1'b0;
    alarmEvent = 1'b0;
    @(negedge sys_clk);
    rd(CTRL_TWO_OFFSET, d);
    check(d, expTwo(8'h80, 1'b1));
    wr(CTRL_TWO_OFFSET, 8'h80);
    rd(CTRL_TWO_OFFSET, d);
    check(d, expTwo(8'h80, 1'b0));
    watch(3, 0);
    check(acc, 8'h00);
    // enabled alarm: flag one cycle after the event, interrupt level a cycle later
    pulse(1'b0);
    check(acc, 8'h03);
    conclude();
  end
endmodule // rtc_control_status_regs_tb
